// >>> inc/sld_pkg.sv
// Constants for the segment LCD driver: register map, field layout,
// reset values, drive level codes and divider figures.
// Assumes a byte-wide register port and a single reference clock.
package sld_pkg;

	// Register indices on the plain register port
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_CLK = 4'h1;
	localparam logic [3:0] REG_SEG_FIRST = 4'h2;
	localparam int SEG_REGS = 13;
	localparam int FP_COUNT = 25;
	localparam int BP_COUNT = 4;

	// Display control register fields
	localparam int CTRL_EN_BIT = 7;
	localparam int CTRL_FAST_BIT = 6;
	localparam int CTRL_LOWCUR_BIT = 5;
	localparam int CTRL_CON_LSB = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_MASK = 8'hef;

	// Base clock register fields
	localparam int CLK_BOOST_LSB = 6;
	localparam int CLK_DUTY_LSB = 4;
	localparam int CLK_SEL_LSB = 0;
	localparam logic [7:0] CLK_RESET = 8'h00;
	localparam logic [7:0] CLK_MASK = 8'hf7;
	localparam logic [7:0] SEG_RESET = 8'h00;

	// Duty codes
	typedef enum logic [1:0] {
		SLD_DUTY_STATIC = 2'b00,
		SLD_DUTY_THIRD = 2'b01,
		SLD_DUTY_QUARTER = 2'b10,
		SLD_DUTY_UNUSED = 2'b11
	} sld_duty_t;

	// Fast-charge pulse: base period shifted right by this plus the code
	localparam int BOOST_SHIFT_BASE = 5;
	localparam logic [1:0] BOOST_CODE_MAX = 2'b10;

	// Drive level codes on each plane output
	localparam logic [1:0] LVL_VLCD = 2'h0;
	localparam logic [1:0] LVL_TWO_THIRD = 2'h1;
	localparam logic [1:0] LVL_ONE_THIRD = 2'h2;
	localparam logic [1:0] LVL_BIAS = 2'h3;

	// Base clock divider: smallest ratio, doubled per select step
	localparam int BASE_DIV_MIN_DEFAULT = 256;
	localparam int DIV_W = 17;

endpackage

// >>> hw/sld_core.sv
// Segment LCD driver: register file, base clock divider, plane waveform
// sequencer, fast-charge timing, pin role selection and stop handling.
// Assumes a same-clock register master and same-clock system signals.
//
// Functional notes
// - Up to 25 frontplanes and 4 backplanes, combination set by duty.
// - Thirteen segment registers, two frontplanes each except the last, which holds frontplane 24.
// - Segment bit one gives ON waveform, zero gives OFF waveform.
// - Enable low blanks display, planes at supply, ladder disconnected.
// - Static drives backplane 0, third duty three, quarter duty four.
// - When enabled, periodic backplane waveforms run continuously.
// - Shared pin is frontplane 0 or backplane 3 by duty field.
// - Frontplanes 3-24 take display role only with enable and group enable, 1-2 with enable.
// - Base clock divides reference by selected ratio and times all steps.
// - Frame lasts duty-count base clock periods.
// - Low-current bit selects the high-value ladder resistors.
// - Fast charge pulses low resistance at each switching edge.
// - Pulse lasts base period divided by 32, 64 or 128.
// - Contrast field gives sixteen bias settings.
// - Wait mode keeps waveforms running as in run mode.
// - Oscillator-in-stop option keeps the driver running in stop.
// - Without that option the driver goes inactive in stop.
// - Stop leaves every register unchanged.
// - Leaving stop resumes waveforms from retained settings.
// - Twenty-eight pins: three backplanes, one shared, 24 frontplanes.
// - Duty 00 static, 01 third, 10 quarter; reset clears it.
// - Boost 00, 01, 10 give 1/32, 1/64, 1/128; reset clears it.
// - Ladder follows low-current first, then fast charge; reset clears.
// - Enable bit read/write, reset clear, drives plane waveforms.
`timescale 1ns/10ps

module sld_core #(
	parameter int BASE_DIV_MIN = sld_pkg::BASE_DIV_MIN_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	input wire logic portEDisplayEn,
	input wire logic portDDisplayEn,
	input wire logic portCDisplayEn,
	input wire logic stopMode,
	input wire logic oscRunsInStop,
	output logic [5:0] bpLevel,
	output logic [1:0] sharedLevel,
	output logic sharedIsBackplane,
	output logic [47:0] fpLevel,
	output logic [23:0] fpDisplayEn,
	output logic ladderConnect,
	output logic ladderLowRes,
	output logic [3:0] contrastLevel
);

	logic [7:0] ctrlReg;
	logic [7:0] clkReg;
	logic [7:0] segReg [sld_pkg::SEG_REGS];
	logic [7:0] segShadow [sld_pkg::SEG_REGS];
	logic [sld_pkg::DIV_W-1:0] divCnt;
	logic [sld_pkg::DIV_W-1:0] divRatio;
	logic [sld_pkg::DIV_W-1:0] boostCnt;
	logic [sld_pkg::DIV_W-1:0] next_boostLoad;
	logic [1:0] phase;
	logic [1:0] lastPhase;
	logic polarity;
	logic enable;
	logic running;
	logic stepTick;
	logic frameEnd;
	logic [1:0] duty;
	logic [1:0] boost;
	logic [1:0] next_bp [sld_pkg::BP_COUNT];
	logic [1:0] next_fp [sld_pkg::FP_COUNT];

	assign enable = ctrlReg[sld_pkg::CTRL_EN_BIT];
	assign duty = clkReg[sld_pkg::CLK_DUTY_LSB +: 2];
	assign boost = clkReg[sld_pkg::CLK_BOOST_LSB +: 2];
	// Wait mode has no input here: waveforms simply keep running.
	assign running = enable && !(stopMode && !oscRunsInStop);
	assign divRatio = sld_pkg::DIV_W'(BASE_DIV_MIN)
		<< clkReg[sld_pkg::CLK_SEL_LSB +: 3];
	assign stepTick = running && (divCnt >= divRatio - 1'b1);
	assign lastPhase = (duty == sld_pkg::SLD_DUTY_THIRD) ? 2'd2 :
		(duty == sld_pkg::SLD_DUTY_QUARTER) ? 2'd3 : 2'd0;
	assign frameEnd = stepTick && (phase >= lastPhase);

	// Control registers; stop mode never touches them
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrlReg <= sld_pkg::CTRL_RESET;
			clkReg <= sld_pkg::CLK_RESET;
		end
		else if (regWr)
		begin
			if (regAddr == sld_pkg::REG_CTRL)
				ctrlReg <= regWrData & sld_pkg::CTRL_MASK;
			if (regAddr == sld_pkg::REG_CLK)
				clkReg <= regWrData & sld_pkg::CLK_MASK;
		end
	end

	// Segment data registers and frame-aligned shadow copy
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < sld_pkg::SEG_REGS; i++)
			begin
				segReg[i] <= sld_pkg::SEG_RESET;
				segShadow[i] <= sld_pkg::SEG_RESET;
			end
		end
		else
		begin
			for (int i = 0; i < sld_pkg::SEG_REGS; i++)
			begin
				if (regWr && regAddr == sld_pkg::REG_SEG_FIRST + 4'(i))
					segReg[i] <= regWrData;
				if (frameEnd || !enable)
					segShadow[i] <= segReg[i];
			end
		end
	end

	// Read port: data in the cycle after the strobe, zero elsewhere
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			regRdData <= 8'h00;
		else if (!regRd)
			regRdData <= 8'h00;
		else if (regAddr == sld_pkg::REG_CTRL)
			regRdData <= ctrlReg;
		else if (regAddr == sld_pkg::REG_CLK)
			regRdData <= clkReg;
		else if (regAddr >= sld_pkg::REG_SEG_FIRST &&
			regAddr < sld_pkg::REG_SEG_FIRST + 4'(sld_pkg::SEG_REGS))
			regRdData <= segReg[regAddr - sld_pkg::REG_SEG_FIRST];
		else
			regRdData <= 8'h00;
	end

	// Base clock divider; holds in stop so it resumes where it left off
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			divCnt <= '0;
		else if (!enable)
			divCnt <= '0;
		else if (running)
			divCnt <= stepTick ? '0 : divCnt + 1'b1;
	end

	// Step counter within a frame, polarity flips each frame
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			phase <= 2'd0;
			polarity <= 1'b0;
		end
		else if (!enable)
		begin
			phase <= 2'd0;
			polarity <= 1'b0;
		end
		else if (stepTick)
		begin
			phase <= frameEnd ? 2'd0 : phase + 2'd1;
			if (frameEnd)
				polarity <= !polarity;
		end
		else if (phase > lastPhase)
			phase <= 2'd0;
	end

	// Fast-charge pulse length for the current boost code
	always_comb
	begin
		if (boost > sld_pkg::BOOST_CODE_MAX)
			next_boostLoad = divRatio >> (sld_pkg::BOOST_SHIFT_BASE + 2);
		else
			next_boostLoad = divRatio >> (sld_pkg::BOOST_SHIFT_BASE +
				int'(boost));
	end

	// Fast-charge counter restarts at every waveform step edge
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			boostCnt <= '0;
		else if (!running)
			boostCnt <= '0;
		else if (stepTick)
			boostCnt <= next_boostLoad;
		else if (boostCnt != '0)
			boostCnt <= boostCnt - 1'b1;
	end

	// Level selection for every backplane and frontplane
	always_comb
	begin
		logic [3:0] bits;
		logic on;
		bits = 4'h0;
		on = 1'b0;
		for (int b = 0; b < sld_pkg::BP_COUNT; b++)
		begin
			if (duty == sld_pkg::SLD_DUTY_THIRD ||
				duty == sld_pkg::SLD_DUTY_QUARTER)
			begin
				if (b > int'(lastPhase))
					next_bp[b] = sld_pkg::LVL_VLCD;
				else if (2'(b) == phase)
					next_bp[b] = polarity ? sld_pkg::LVL_BIAS :
						sld_pkg::LVL_VLCD;
				else
					next_bp[b] = polarity ? sld_pkg::LVL_TWO_THIRD :
						sld_pkg::LVL_ONE_THIRD;
			end
			else if (b == 0)
				next_bp[b] = polarity ? sld_pkg::LVL_BIAS :
					sld_pkg::LVL_VLCD;
			else
				next_bp[b] = sld_pkg::LVL_VLCD;
		end
		for (int f = 0; f < sld_pkg::FP_COUNT; f++)
		begin
			bits = segShadow[f / 2][(f % 2) * 4 +: 4];
			if (duty == sld_pkg::SLD_DUTY_THIRD ||
				duty == sld_pkg::SLD_DUTY_QUARTER)
			begin
				on = bits[phase];
				if (on)
					next_fp[f] = polarity ? sld_pkg::LVL_VLCD :
						sld_pkg::LVL_BIAS;
				else
					next_fp[f] = polarity ? sld_pkg::LVL_ONE_THIRD :
						sld_pkg::LVL_TWO_THIRD;
			end
			else
			begin
				on = bits[0];
				next_fp[f] = (on ^ polarity) ? sld_pkg::LVL_BIAS :
					sld_pkg::LVL_VLCD;
			end
		end
	end

	// Registered plane outputs; blank at supply level when inactive
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bpLevel <= '0;
			sharedLevel <= sld_pkg::LVL_VLCD;
			fpLevel <= '0;
		end
		else if (!running)
		begin
			bpLevel <= '0;
			sharedLevel <= sld_pkg::LVL_VLCD;
			fpLevel <= '0;
		end
		else
		begin
			bpLevel <= {next_bp[2], next_bp[1], next_bp[0]};
			sharedLevel <= (duty == sld_pkg::SLD_DUTY_QUARTER) ?
				next_bp[3] : next_fp[0];
			for (int f = 1; f < sld_pkg::FP_COUNT; f++)
				fpLevel[(f - 1) * 2 +: 2] <= next_fp[f];
		end
	end

	// Pin roles, ladder control and contrast code
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sharedIsBackplane <= 1'b0;
			fpDisplayEn <= '0;
			ladderConnect <= 1'b0;
			ladderLowRes <= 1'b0;
			contrastLevel <= 4'h0;
		end
		else
		begin
			sharedIsBackplane <= duty == sld_pkg::SLD_DUTY_QUARTER;
			fpDisplayEn[1:0] <= {2{enable}};
			fpDisplayEn[9:2] <= {8{enable && portEDisplayEn}};
			fpDisplayEn[17:10] <= {8{enable && portDDisplayEn}};
			fpDisplayEn[23:18] <= {6{enable && portCDisplayEn}};
			ladderConnect <= running;
			ladderLowRes <= !ctrlReg[sld_pkg::CTRL_LOWCUR_BIT] ||
				(ctrlReg[sld_pkg::CTRL_FAST_BIT] && boostCnt != '0);
			contrastLevel <= ctrlReg[sld_pkg::CTRL_CON_LSB +: 4];
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	property p_blank;
		!running |=> !ladderConnect && bpLevel == '0 && fpLevel == '0;
	endproperty
	a_blank: assert property (p_blank)
		else $error("inactive driver not blanked");

	property p_shared_role;
		duty == sld_pkg::SLD_DUTY_QUARTER |=> sharedIsBackplane;
	endproperty
	a_shared_role: assert property (p_shared_role)
		else $error("shared pin not backplane at quarter duty");

	property p_low_res;
		!ctrlReg[sld_pkg::CTRL_LOWCUR_BIT] |=> ladderLowRes;
	endproperty
	a_low_res: assert property (p_low_res)
		else $error("low resistance missing with low-current clear");

	property p_high_res;
		ctrlReg[sld_pkg::CTRL_LOWCUR_BIT] &&
			!ctrlReg[sld_pkg::CTRL_FAST_BIT] |=> !ladderLowRes;
	endproperty
	a_high_res: assert property (p_high_res)
		else $error("high resistance not selected");

	property p_phase_range;
		running |-> phase <= lastPhase || $past(duty) != duty;
	endproperty
	a_phase_range: assert property (p_phase_range)
		else $error("frame step out of range");

	property p_boost_len;
		stepTick |=> boostCnt == $past(next_boostLoad) && boostCnt != '0;
	endproperty
	a_boost_len: assert property (p_boost_len)
		else $error("fast-charge length wrong");

	property p_stop_hold;
		enable && stopMode && !oscRunsInStop |=> $stable(divCnt);
	endproperty
	a_stop_hold: assert property (p_stop_hold)
		else $error("divider moved in stop");

	property p_frame_latch;
		enable && !frameEnd |=> $stable(segShadow[0]);
	endproperty
	a_frame_latch: assert property (p_frame_latch)
		else $error("segment data taken mid-frame");

	property p_port_role;
		!enable |=> fpDisplayEn == '0;
	endproperty
	a_port_role: assert property (p_port_role)
		else $error("display role without enable");

endmodule

// >>> dv/sld_panel.sv
// Passive glass model: latches each crossing that sees full drive swing.
// Assumes level codes of sld_pkg and backplane wiring given by the bench.
`timescale 1ns/10ps
module sld_panel (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic clear,
	input wire logic [3:0] bpUsed,
	input wire logic [5:0] bpLevel,
	input wire logic [1:0] sharedLevel,
	input wire logic sharedIsBackplane,
	input wire logic [47:0] fpLevel,
	output logic [95:0] segDark
);
	logic [1:0] bp [4];
	// Backplane lines seen by the glass
	always_comb
	begin
		bp[0] = bpLevel[1:0];
		bp[1] = bpLevel[3:2];
		bp[2] = bpLevel[5:4];
		bp[3] = sharedIsBackplane ? sharedLevel : sld_pkg::LVL_VLCD;
	end
	// Crossing darkens on supply against bias; unwired lines ignored
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			segDark <= '0;
		else
			for (int f = 0; f < 24; f++)
				for (int b = 0; b < 4; b++)
					if (clear)
						segDark[f*4+b] <= 1'b0;
					else if (bpUsed[b] && bp[b][0] == bp[b][1] &&
						(bp[b] ^ fpLevel[f*2+:2]) == 2'h3)
						segDark[f*4+b] <= 1'b1;
	end
endmodule

// >>> dv/segment_lcd_driver_test.sv
// Self-checking bench for the segment LCD driver core with a glass model.
// Assumes sld_pkg, sld_core and sld_panel are compiled ahead of it.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
	n_mismatch++; $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
module segment_lcd_driver_test;
	logic ref_clk = 1'b0, arst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
	logic stopMode = 1'b0, oscRunsInStop = 1'b0, clear = 1'b0;
	logic portEDisplayEn = 1'b0, portDDisplayEn = 1'b0, portCDisplayEn = 1'b0;
	logic [3:0] regAddr = 4'h0, bpUsed = 4'h0, contrastLevel;
	logic [7:0] regWrData = 8'h00, regRdData;
	logic [5:0] bpLevel;
	logic [1:0] sharedLevel;
	logic sharedIsBackplane, ladderConnect, ladderLowRes;
	logic [47:0] fpLevel;
	logic [23:0] fpDisplayEn;
	logic [95:0] segDark, expDark;
	logic [15:0] lfsr = 16'h3165;
	logic [7:0] oldD [13], newD [13];
	int n_mismatch = 0, checked = 0, w, per, t;
	// Design with a short base divide, glass on its plane outputs
	sld_core #(.BASE_DIV_MIN(128)) i_dut (.ref_clk, .arst_n, .regAddr,
		.regWrData, .regWr, .regRd, .regRdData, .portEDisplayEn,
		.portDDisplayEn, .portCDisplayEn, .stopMode, .oscRunsInStop,
		.bpLevel, .sharedLevel, .sharedIsBackplane, .fpLevel, .fpDisplayEn,
		.ladderConnect, .ladderLowRes, .contrastLevel);
	sld_panel i_panel (.ref_clk, .arst_n, .clear, .bpUsed, .bpLevel,
		.sharedLevel, .sharedIsBackplane, .fpLevel, .segDark);
	// 125 MHz clock
	always #4 ref_clk = ~ref_clk;
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr[7:0];
	endfunction
	// Expected backplane and frontplane level codes per base step
	function automatic logic [1:0] ebp(int n, int b, int k);
		if (b >= n) return 2'h0;
		if ((k / n) % 2 == 0) return (b == k % n) ? 2'h0 : 2'h2;
		return (b == k % n) ? 2'h3 : 2'h1;
	endfunction
	function automatic logic [1:0] efp(int n, logic on, int k);
		logic pol;
		pol = ((k / n) % 2) != 0;
		if (n == 1) return (on ^ pol) ? 2'h3 : 2'h0;
		return on ? (pol ? 2'h0 : 2'h3) : (pol ? 2'h2 : 2'h1);
	endfunction
	// Segment bit for one frontplane; old data in first frame only
	function automatic logic sb(int f, int k, int n);
		int i;
		i = (f % 2) * 4 + k % n;
		return (k < n) ? oldD[f / 2][i] : newD[f / 2][i];
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		cyc(1);
		regWr <= 1'b0;
		cyc(1);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] ex);
		regAddr <= a;
		regRd <= 1'b1;
		cyc(1);
		regRd <= 1'b0;
		#1 `CHK("regRdData", ex, regRdData)
		cyc(1);
	endtask
	task automatic rise(output int n);
		logic pv;
		n = 0;
		do
		begin
			pv = ladderLowRes;
			cyc(1);
			n++;
		end
		while (!(ladderLowRes === 1'b1 && pv === 1'b0) && n < 20000);
	endtask
	// Width of one low-resistance pulse and spacing to the next
	task automatic pulse();
		rise(t);
		rise(t);
		w = 0;
		while (ladderLowRes === 1'b1 && w < 20000)
		begin
			cyc(1);
			w++;
		end
		rise(t);
		per = w + t;
	endtask
	// Two frames of one duty, new segment data written mid-frame
	task automatic walk(input logic [1:0] du, input int n, input logic [3:0] u);
		logic pv;
		bpUsed <= u;
		wr(sld_pkg::REG_CTRL, 8'h00);
		for (int i = 0; i < 13; i++)
		begin
			oldD[i] = rnd();
			newD[i] = rnd();
			wr(sld_pkg::REG_SEG_FIRST + 4'(i), oldD[i]);
		end
		wr(sld_pkg::REG_CLK, {2'b00, du, 4'h0});
		wr(sld_pkg::REG_CTRL, 8'h80);
		t = 0;
		do
		begin
			pv = |bpLevel[1:0];
			cyc(1);
			t++;
		end
		while (!(bpLevel[1:0] === 2'h0 && pv) && t < 5000);
		cyc(64);
		for (int k = 0; k < 2 * n; k++)
		begin
			for (int b = 0; b < 3; b++)
				`CHK("bpLevel", ebp(n, b, k), bpLevel[2*b+:2])
			`CHK("sharedLevel", n == 4 ? ebp(n, 3, k) :
				efp(n, sb(0, k, n), k), sharedLevel)
			`CHK("sharedIsBackplane", n == 4, sharedIsBackplane)
			for (int f = 1; f < 25; f++)
				`CHK("fpLevel", efp(n, sb(f, k, n), k), fpLevel[2*f-2+:2])
			if (k == 0)
				for (int i = 0; i < 13; i++)
					wr(sld_pkg::REG_SEG_FIRST + 4'(i), newD[i]);
			clear <= (k == n);
			cyc(1);
			clear <= 1'b0;
			cyc(k == 0 ? 101 : 127);
		end
		expDark = '0;
		for (int f = 1; f < 25; f++)
			for (int b = 0; b < n; b++)
				expDark[(f-1)*4+b] = sb(f, n + b, n);
		`CHK("segDark", expDark, segDark)
	endtask
	task finish_test();
		if (n_mismatch == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Watchdog well beyond the expected run of some 12000 cycles
	initial
	begin
		#400000;
		n_mismatch++;
		finish_test();
	end
	// Main sequence
	initial
	begin
		cyc(16);
		#1 `CHK("ladderConnect", 1'b0, ladderConnect)
		@(posedge ref_clk);
		arst_n <= 1'b1;
		cyc(1);
		for (int i = 0; i < 15; i++)
			rd(4'(i), 8'h00);
		wr(4'hf, 8'hff);
		rd(4'hf, 8'h00);
		for (int i = 0; i < 13; i++)
		begin
			oldD[i] = rnd();
			wr(4'(i + 1), oldD[i]);
			rd(4'(i + 1), i == 0 ? oldD[i] & 8'hf7 : oldD[i]);
		end
		for (int c = 0; c < 16; c++)
		begin
			wr(sld_pkg::REG_CTRL, {4'h8, 4'(c)});
			cyc(2);
			`CHK("contrastLevel", 4'(c), contrastLevel)
			rd(sld_pkg::REG_CTRL, {4'h8, 4'(c)});
		end
		for (int g = 0; g < 8; g++)
		begin
			{portCDisplayEn, portDDisplayEn, portEDisplayEn} <= 3'(g);
			cyc(3);
			`CHK("fpDisplayEn", {{6{g[2]}}, {8{g[1]}}, {8{g[0]}}, 2'b11},
				fpDisplayEn)
		end
		walk(2'b00, 1, 4'h1);
		walk(2'b01, 3, 4'h7);
		walk(2'b10, 4, 4'hf);
		for (int i = 0; i < 3; i++)
		begin
			wr(sld_pkg::REG_CTRL, 8'h80 | 8'(i << 5));
			repeat (8)
			begin
				cyc(40);
				`CHK("ladderLowRes", i != 1, ladderLowRes)
			end
		end
		wr(sld_pkg::REG_CTRL, 8'he0);
		for (int s = 0; s < 4; s++)
		begin
			wr(sld_pkg::REG_CLK, {2'(s), 3'h0, 3'(s)});
			pulse();
			`CHK("pulse width", (128 << s) >> (5 + (s > 2 ? 2 : s)), w)
			`CHK("step period", 128 << s, per)
		end
		wr(sld_pkg::REG_CLK, 8'h00);
		stopMode <= 1'b1;
		cyc(3);
		`CHK("ladderConnect", 1'b0, ladderConnect)
		`CHK("bpLevel", 6'h00, bpLevel)
		rd(sld_pkg::REG_CTRL, 8'he0);
		stopMode <= 1'b0;
		pulse();
		`CHK("step period", 128, per)
		`CHK("ladderConnect", 1'b1, ladderConnect)
		stopMode <= 1'b1;
		oscRunsInStop <= 1'b1;
		pulse();
		`CHK("step period", 128, per)
		`CHK("ladderConnect", 1'b1, ladderConnect)
		wr(sld_pkg::REG_CTRL, 8'h60);
		cyc(3);
		`CHK("blank", 81'h0, {ladderConnect, bpLevel, sharedLevel, fpLevel,
			fpDisplayEn})
		finish_test();
	end
endmodule
